// ===== common/dbp_pkg.sv
// Package of constants and types for the data buffer peripheral access block.
// Functional notes
// - Buffer is four nibbles at 0CH to 0FH.
// - Bit 3 of 0CH is MSB, 0FH bit0 LSB.
// - Ordinary memory access reads and writes buffer.
// - Table read copies pointed program word into buffer.
// - Input tbl_wide_i sets table width.
// - Eight-bit table read loads two low nibbles.
// - Table read holds one return stack level.
// - Peripheral read copies addressed register into buffer.
// - Peripheral write stores buffer into addressed register.
// - Reading write-only control register gives undefined.
// - Writing read-only register changes nothing.
// - Unused locations read undefined, writes ignored.
// - Shift registers 03H, 04H: 8-bit, undefined reset.
// - Timer modulos reset FF, kept on CE.
// - Timer counts read-only, reset zero, kept on CE.
// - Pointer at 40H, cleared by resets, kept stopped.
// - Buffer stack port 41H, kept on CE, stop.
// - Synth divide upper 16 bits, flag low bit.
// - Frequency result read-only, cleared on every reset.
// - Duty registers nine bits, reset 1FF, kept CE.
// - Converter reference clears on CE only hardware mode.
// - Port direction at 6FH, one is output.
package dbp_pkg;
   localparam logic [6:0]  MEM_BUF_N3   = 7'h0C;
   localparam logic [6:0]  MEM_BUF_N0   = 7'h0F;
   localparam logic [6:0]  MEM_DIR_ADDR = 7'h6F;
   localparam logic [3:0]  BANK_BUF     = 4'h0;
   localparam logic [3:0]  BANK_DIR     = 4'hF;
   localparam logic [6:0]  P_ADC        = 7'h02;
   localparam logic [6:0]  P_SIO_A      = 7'h03;
   localparam logic [6:0]  P_SIO_B      = 7'h04;
   localparam logic [6:0]  P_TMA_M      = 7'h1A;
   localparam logic [6:0]  P_TMA_C      = 7'h1B;
   localparam logic [6:0]  P_TMB_M      = 7'h1C;
   localparam logic [6:0]  P_TMB_C      = 7'h1D;
   localparam logic [6:0]  P_TMC_M      = 7'h1E;
   localparam logic [6:0]  P_TMC_C      = 7'h1F;
   localparam logic [6:0]  P_PTR        = 7'h40;
   localparam logic [6:0]  P_STK        = 7'h41;
   localparam logic [6:0]  P_SYN        = 7'h42;
   localparam logic [6:0]  P_FRQ        = 7'h43;
   localparam logic [6:0]  P_PWM_A      = 7'h44;
   localparam logic [6:0]  P_PWM_B      = 7'h45;
   localparam logic [6:0]  P_PWM_C      = 7'h46;
   localparam logic [7:0]  TM_MOD_RST   = 8'hFF;
   localparam logic [7:0]  TM_CNT_RST   = 8'h00;
   localparam logic [8:0]  PWM_RST      = 9'h1FF;
   localparam logic [15:0] UNDEF_VALUE  = 16'h0000;
   // Kinds of buffer operation presented by the instruction decoder.
   typedef enum logic [3:0] {
      DBP_OP_NONE = 4'h0,
      DBP_OP_TBL  = 4'h1,
      DBP_OP_GET  = 4'h2,
      DBP_OP_PUT  = 4'h3
   } dbp_op_t;
   // Table read sequencer, one-hot.
   typedef enum logic [2:0] {
      DBP_TS_IDLE = 3'b001,
      DBP_TS_WAIT = 3'b010,
      DBP_TS_DONE = 3'b100
   } dbp_tstate_t;
endpackage

// ===== common/dbp_periph_if.sv
// Interface carrying peripheral register transfers between the two modules.
`timescale 1ns/1ps
`default_nettype none
interface dbp_periph_if;
   logic        wr;
   logic        rd;
   logic [6:0]  addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   modport master (output wr, output rd, output addr, output wdata,
                   input rdata);
   modport slave  (input wr, input rd, input addr, input wdata,
                   output rdata);
endinterface
`default_nettype wire

// ===== core/dbp_periph_regs.sv
// Peripheral register bank reached by put and get transfers.
`timescale 1ns/1ps
`default_nettype none
module dbp_periph_regs (
   input  wire logic          clk_i,
   input  wire logic          rst_n_i,
   input  wire logic          ce_rst_i,
   input  wire logic          clk_stop_i,
   input  wire logic          adc_hw_mode_i,
   input  wire logic [23:0]   tm_count_i,
   input  wire logic [15:0]   freq_count_i,
   input  wire logic          freq_load_i,
   input  wire logic [15:0]   ptr_tbl_i,
   input  wire logic          ptr_tbl_we_i,
   output logic      [15:0]   ptr_o,
   output logic      [15:0]   per_o [0:11],
   dbp_periph_if.slave        bus
);
   // State of all peripheral registers except the timer counts.
   typedef struct packed {
      logic [7:0]  adc;
      logic [7:0]  sio_a;
      logic [7:0]  sio_b;
      logic [23:0] tm_mod;
      logic [15:0] ptr;
      logic [15:0] stk;
      logic [15:0] syn;
      logic [15:0] frq;
      logic [26:0] pwm;
   } dbp_preg_t;
   dbp_preg_t s_q;
   dbp_preg_t s_d;
   // Register update, with reset classes applied after software writes.
   always_comb begin
      s_d = s_q;
      if (bus.wr) begin
         unique case (bus.addr)
            dbp_pkg::P_ADC:   s_d.adc = bus.wdata[7:0];
            dbp_pkg::P_SIO_A: s_d.sio_a = bus.wdata[7:0];
            dbp_pkg::P_SIO_B: s_d.sio_b = bus.wdata[7:0];
            dbp_pkg::P_TMA_M: s_d.tm_mod[7:0] = bus.wdata[7:0];
            dbp_pkg::P_TMB_M: s_d.tm_mod[15:8] = bus.wdata[7:0];
            dbp_pkg::P_TMC_M: s_d.tm_mod[23:16] = bus.wdata[7:0];
            dbp_pkg::P_PTR:   s_d.ptr = bus.wdata;
            dbp_pkg::P_STK:   s_d.stk = bus.wdata;
            dbp_pkg::P_SYN:   s_d.syn = bus.wdata;
            dbp_pkg::P_PWM_A: s_d.pwm[8:0] = bus.wdata[8:0];
            dbp_pkg::P_PWM_B: s_d.pwm[17:9] = bus.wdata[8:0];
            dbp_pkg::P_PWM_C: s_d.pwm[26:18] = bus.wdata[8:0];
            default: ; // Read-only and unused: no effect
         endcase
      end
      if (ptr_tbl_we_i) begin
         s_d.ptr = ptr_tbl_i;
      end
      if (freq_load_i) begin
         s_d.frq = freq_count_i;
      end
      // CE reset and clock stop classes.
      if (ce_rst_i) begin
         s_d.ptr = '0;
         s_d.frq = '0;
         if (adc_hw_mode_i) begin
            s_d.adc = '0;
         end
      end
      if (clk_stop_i) begin
         s_d.tm_mod = {3{dbp_pkg::TM_MOD_RST}};
         s_d.frq = '0;
         s_d.pwm = {3{dbp_pkg::PWM_RST}};
         if (adc_hw_mode_i) begin
            s_d.adc = '0;
         end
      end
   end
   // Power-on and watchdog resets arrive on rst_n_i.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '{adc: 8'h00, sio_a: 8'h00, sio_b: 8'h00,
                  tm_mod: {3{dbp_pkg::TM_MOD_RST}}, ptr: 16'h0000,
                  stk: 16'h0000, syn: 16'h0000, frq: 16'h0000,
                  pwm: {3{dbp_pkg::PWM_RST}}};
      end else begin
         s_q <= s_d;
      end
   end
   // Read multiplexer.
   always_comb begin
      unique case (bus.addr)
         dbp_pkg::P_ADC:   bus.rdata = {8'h00, s_q.adc};
         dbp_pkg::P_SIO_A: bus.rdata = {8'h00, s_q.sio_a};
         dbp_pkg::P_SIO_B: bus.rdata = {8'h00, s_q.sio_b};
         dbp_pkg::P_TMA_M: bus.rdata = {8'h00, s_q.tm_mod[7:0]};
         dbp_pkg::P_TMA_C: bus.rdata = {8'h00, tm_count_i[7:0]};
         dbp_pkg::P_TMB_M: bus.rdata = {8'h00, s_q.tm_mod[15:8]};
         dbp_pkg::P_TMB_C: bus.rdata = {8'h00, tm_count_i[15:8]};
         dbp_pkg::P_TMC_M: bus.rdata = {8'h00, s_q.tm_mod[23:16]};
         dbp_pkg::P_TMC_C: bus.rdata = {8'h00, tm_count_i[23:16]};
         dbp_pkg::P_PTR:   bus.rdata = s_q.ptr;
         dbp_pkg::P_STK:   bus.rdata = s_q.stk;
         dbp_pkg::P_SYN:   bus.rdata = s_q.syn;
         dbp_pkg::P_FRQ:   bus.rdata = s_q.frq;
         dbp_pkg::P_PWM_A: bus.rdata = {7'h00, s_q.pwm[8:0]};
         dbp_pkg::P_PWM_B: bus.rdata = {7'h00, s_q.pwm[17:9]};
         dbp_pkg::P_PWM_C: bus.rdata = {7'h00, s_q.pwm[26:18]};
         default:          bus.rdata = dbp_pkg::UNDEF_VALUE;
      endcase
   end
   // Register values toward the peripherals.
   assign ptr_o     = s_q.ptr;
   assign per_o[0]  = {8'h00, s_q.adc};
   assign per_o[1]  = {8'h00, s_q.sio_a};
   assign per_o[2]  = {8'h00, s_q.sio_b};
   assign per_o[3]  = {8'h00, s_q.tm_mod[7:0]};
   assign per_o[4]  = {8'h00, s_q.tm_mod[15:8]};
   assign per_o[5]  = {8'h00, s_q.tm_mod[23:16]};
   assign per_o[6]  = s_q.stk;
   assign per_o[7]  = s_q.syn;
   assign per_o[8]  = s_q.frq;
   assign per_o[9]  = {7'h00, s_q.pwm[8:0]};
   assign per_o[10] = {7'h00, s_q.pwm[17:9]};
   assign per_o[11] = {7'h00, s_q.pwm[26:18]};
endmodule
`default_nettype wire

// ===== core/dbp_top.sv
// Data buffer with table reads and peripheral put and get transfers.
`timescale 1ns/1ps
`default_nettype none
module dbp_top (
   input  wire logic          clk_i,
   input  wire logic          rst_n_i,
   input  wire logic          ce_rst_i,
   input  wire logic          clk_stop_i,
   input  wire logic          adc_hw_mode_i,
   input  wire logic          mem_we_i,
   input  wire logic [3:0]    mem_bank_i,
   input  wire logic [6:0]    mem_addr_i,
   input  wire logic [3:0]    mem_wdata_i,
   output logic      [3:0]    mem_rdata_o,
   input  wire logic [3:0]    op_i,
   input  wire logic [6:0]    op_paddr_i,
   input  wire logic          tbl_wide_i,
   output logic      [15:0]   pmem_addr_o,
   output logic               pmem_req_o,
   input  wire logic [15:0]   pmem_data_i,
   input  wire logic          pmem_valid_i,
   output logic               stack_hold_o,
   output logic               busy_o,
   input  wire logic          synth_count_low_bit_i,
   output logic      [16:0]   synth_count_o,
   input  wire logic [23:0]   tm_count_i,
   input  wire logic [15:0]   freq_count_i,
   input  wire logic          freq_load_i,
   output logic      [15:0]   transfer_buffer_o,
   output logic      [3:0]    port_a0_dir_o,
   output logic      [8:0]    pwm_duty_a_o,
   output logic      [8:0]    pwm_duty_b_o,
   output logic      [8:0]    pwm_duty_c_o,
   output logic      [7:0]    adc_reference_level_o
);
   ////////////////////////////////////////////////////////////////////////
   // Reset release and block state.
   typedef struct packed {
      logic [15:0]          buf_w;
      logic [3:0]           dir;
      dbp_pkg::dbp_tstate_t ts;
      logic                 tbl8;
      logic [1:0]           rsync;
   } dbp_state_t;
   dbp_state_t  s_q;
   dbp_state_t  s_d;
   logic        rst_n;
   logic [15:0] per_w [0:11];
   logic [15:0] ptr;
   logic        buf_sel;
   logic [1:0]  nib_idx;
   dbp_periph_if pif ();
   // State of the block while reset is applied or still being released.
   localparam dbp_state_t RST_STATE = '{buf_w: 16'h0000, dir: 4'h0,
                                       ts: dbp_pkg::DBP_TS_IDLE,
                                       tbl8: 1'b0, rsync: 2'b00};
   // Second synchroniser stage is the released reset for the whole block.
   assign rst_n = s_q.rsync[1];
   ////////////////////////////////////////////////////////////////////////
   // Nibble position of a data memory address within the buffer word.
   function automatic logic [1:0] nib_of(input logic [6:0] a);
      logic [6:0] d;
      d = dbp_pkg::MEM_BUF_N0 - a;
      return d[1:0];
   endfunction
   assign buf_sel = (mem_bank_i == dbp_pkg::BANK_BUF) &&
                    (mem_addr_i >= dbp_pkg::MEM_BUF_N3) &&
                    (mem_addr_i <= dbp_pkg::MEM_BUF_N0);
   assign nib_idx = nib_of(mem_addr_i);
   // Peripheral transfer strobes.
   assign pif.wr    = (op_i == dbp_pkg::DBP_OP_PUT);
   assign pif.rd    = (op_i == dbp_pkg::DBP_OP_GET);
   assign pif.addr  = op_paddr_i;
   assign pif.wdata = s_q.buf_w;
   ////////////////////////////////////////////////////////////////////////
   // Next state for buffer, direction register and table sequencer.
   always_comb begin
      s_d       = s_q;
      s_d.rsync = {s_q.rsync[0], 1'b1}; // Two-stage reset release.
      if (mem_we_i && buf_sel) begin
         s_d.buf_w[nib_idx*4 +: 4] = mem_wdata_i;
      end
      if (mem_we_i && (mem_bank_i == dbp_pkg::BANK_DIR) &&
          (mem_addr_i == dbp_pkg::MEM_DIR_ADDR)) begin
         s_d.dir = mem_wdata_i;
      end
      if (pif.rd) begin
         if (pif.rdata[15:8] == 8'h00 && op_paddr_i < dbp_pkg::P_PTR) begin
            s_d.buf_w[7:0] = pif.rdata[7:0];
         end else begin
            s_d.buf_w = pif.rdata;
         end
      end
      unique case (s_q.ts)
         dbp_pkg::DBP_TS_IDLE: begin
            if (op_i == dbp_pkg::DBP_OP_TBL) begin
               s_d.tbl8 = !tbl_wide_i;
               s_d.ts   = dbp_pkg::DBP_TS_WAIT;
            end
         end
         dbp_pkg::DBP_TS_WAIT: begin
            if (pmem_valid_i) begin
               if (s_q.tbl8) begin
                  s_d.buf_w[7:0] = pmem_data_i[7:0];
               end else begin
                  s_d.buf_w = pmem_data_i;
               end
               s_d.ts = dbp_pkg::DBP_TS_DONE;
            end
         end
         dbp_pkg::DBP_TS_DONE: begin
            s_d.ts = dbp_pkg::DBP_TS_IDLE;
         end
         default: s_d.ts = dbp_pkg::DBP_TS_IDLE;
      endcase
      // Hold every other field at reset until the release has settled.
      if (!rst_n) begin
         s_d       = RST_STATE;
         s_d.rsync = {s_q.rsync[0], 1'b1};
      end
   end
   // State register; the pin reset clears all of it at once, so the
   // synchroniser and the rest of the state share one single driver.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= RST_STATE;
      end else begin
         s_q <= s_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Peripheral register bank.
   dbp_periph_regs u_regs (
      .clk_i         (clk_i),
      .rst_n_i       (rst_n),
      .ce_rst_i      (ce_rst_i),
      .clk_stop_i    (clk_stop_i),
      .adc_hw_mode_i (adc_hw_mode_i),
      .tm_count_i    (tm_count_i),
      .freq_count_i  (freq_count_i),
      .freq_load_i   (freq_load_i),
      .ptr_tbl_i     (16'h0000),
      .ptr_tbl_we_i  (1'b0),
      .ptr_o         (ptr),
      .per_o         (per_w),
      .bus           (pif)
   );
   ////////////////////////////////////////////////////////////////////////
   // Data memory read port for buffer nibbles and direction register.
   always_comb begin
      if (buf_sel) begin
         mem_rdata_o = s_q.buf_w[nib_idx*4 +: 4];
      end else if ((mem_bank_i == dbp_pkg::BANK_DIR) &&
                   (mem_addr_i == dbp_pkg::MEM_DIR_ADDR)) begin
         mem_rdata_o = s_q.dir;
      end else begin
         mem_rdata_o = 4'h0;
      end
   end
   // Program memory fetch and stack level while a table read runs.
   assign pmem_addr_o  = ptr;
   assign pmem_req_o   = (s_q.ts == dbp_pkg::DBP_TS_WAIT);
   assign stack_hold_o = (s_q.ts != dbp_pkg::DBP_TS_IDLE);
   assign busy_o       = stack_hold_o;
   // Register values toward the peripherals.
   assign synth_count_o = {per_w[7], synth_count_low_bit_i};
   assign transfer_buffer_o     = s_q.buf_w;
   assign port_a0_dir_o         = s_q.dir;
   assign pwm_duty_a_o          = per_w[9][8:0];
   assign pwm_duty_b_o          = per_w[10][8:0];
   assign pwm_duty_c_o          = per_w[11][8:0];
   assign adc_reference_level_o = per_w[0][7:0];
   // Write-only registers are absent here; undefined reads give zero.
endmodule
`default_nettype wire

// ===== bench/dbp_checker.sv
// Port checker for the data buffer block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module dbp_checker (
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic        ce_rst_i,
   input wire logic        clk_stop_i,
   input wire logic        adc_hw_mode_i,
   input wire logic        mem_we_i,
   input wire logic [3:0]  mem_bank_i,
   input wire logic [6:0]  mem_addr_i,
   input wire logic [3:0]  mem_wdata_i,
   input wire logic [3:0]  op_i,
   input wire logic [6:0]  op_paddr_i,
   input wire logic        tbl_wide_i,
   input wire logic        pmem_req_o,
   input wire logic [15:0] pmem_data_i,
   input wire logic        pmem_valid_i,
   input wire logic        stack_hold_o,
   input wire logic        busy_o,
   input wire logic [16:0] synth_count_o,
   input wire logic [15:0] transfer_buffer_o,
   input wire logic [3:0]  port_a0_dir_o,
   input wire logic [8:0]  pwm_duty_a_o,
   input wire logic [7:0]  adc_reference_level_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////////////////////////////////////
   // Decoded requests shared by several properties.
   wire peripheral_write_instr = (op_i == 4'h3);
   wire idle = (op_i == 4'h0);
   sequence s_tbl_op;
      (op_i == 4'h1) && !busy_o;
   endsequence
   sequence s_fetch;
      pmem_req_o && pmem_valid_i;
   endsequence
   ////////////////////////////////////////////////////////////////////////
   a_tbl_launch: assert property (
      s_tbl_op |=> pmem_req_o && busy_o)
      else $error("table read did not request program memory");
   a_tbl_load: assert property (
      s_fetch |=> transfer_buffer_o ==
      ($past(tbl_wide_i) ? $past(pmem_data_i) :
      {$past(transfer_buffer_o[15:8]), $past(pmem_data_i[7:0])}))
      else $error("table word not loaded into the buffer");
   a_tbl_finish: assert property (
      s_fetch |=> !pmem_req_o ##1 !busy_o)
      else $error("table read did not finish in time");
   a_stack_busy: assert property (
      s_tbl_op |=> (stack_hold_o && busy_o) [*3])
      else $error("stack level not held during the table read");
   a_mem_nibble: assert property (
      mem_we_i && idle && mem_bank_i == 4'h0 && mem_addr_i == 7'h0C |=>
      transfer_buffer_o[15:12] == $past(mem_wdata_i))
      else $error("top buffer nibble not written");
   a_get_upper: assert property (
      (op_i == 4'h2) && op_paddr_i == 7'h1B |=>
      transfer_buffer_o[15:8] == $past(transfer_buffer_o[15:8]))
      else $error("byte read disturbed the upper buffer byte");
   a_syn_put: assert property (
      peripheral_write_instr && op_paddr_i == 7'h42 |=>
      synth_count_o[16:1] == $past(transfer_buffer_o))
      else $error("divide value not taken from the buffer");
   a_adc_put: assert property (
      peripheral_write_instr && op_paddr_i == 7'h02 |=>
      adc_reference_level_o == $past(transfer_buffer_o[7:0]))
      else $error("reference level not taken from the buffer");
   a_adc_ce_hw: assert property (
      ce_rst_i && adc_hw_mode_i && idle |=> adc_reference_level_o == 8'h00)
      else $error("reference level kept in hardware mode");
   a_pwm_stop: assert property (
      clk_stop_i && idle |=> pwm_duty_a_o == 9'h1FF)
      else $error("duty not restored on clock stop");
   a_dir_hold: assert property (
      $changed(port_a0_dir_o) |->
      $past(mem_we_i && mem_bank_i == 4'hF && mem_addr_i == 7'h6F))
      else $error("direction changed without a write");
endmodule
bind dbp_top dbp_checker i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .ce_rst_i(ce_rst_i), .clk_stop_i(clk_stop_i), .adc_hw_mode_i(adc_hw_mode_i),
   .mem_we_i(mem_we_i), .mem_bank_i(mem_bank_i), .mem_addr_i(mem_addr_i),
   .mem_wdata_i(mem_wdata_i), .op_i(op_i), .op_paddr_i(op_paddr_i),
   .tbl_wide_i(tbl_wide_i), .pmem_req_o(pmem_req_o),
   .pmem_data_i(pmem_data_i), .pmem_valid_i(pmem_valid_i),
   .stack_hold_o(stack_hold_o), .busy_o(busy_o),
   .synth_count_o(synth_count_o), .transfer_buffer_o(transfer_buffer_o),
   .port_a0_dir_o(port_a0_dir_o), .pwm_duty_a_o(pwm_duty_a_o),
   .adc_reference_level_o(adc_reference_level_o));
`default_nettype wire

// ===== bench/dbp_pmem_model.sv
// Program memory model answering table read fetches.
`timescale 1ns/1ps
`default_nettype none
module dbp_pmem_model (
   input  wire logic        clk_i,
   input  wire logic [1:0]  lat_i,
   input  wire logic [15:0] addr_i,
   input  wire logic        req_i,
   output logic      [15:0] data_o,
   output logic             valid_o
);
   logic [1:0] wait_q = 2'h0;
   initial data_o = 16'h0000;
   initial valid_o = 1'b0;
   // Waits the commanded latency, shows the word for one cycle, then scrambles.
   always @(posedge clk_i) begin
      if (req_i && !valid_o && wait_q == lat_i) begin
         valid_o <= 1'b1;
         data_o <= addr_i ^ 16'h5A3C;
      end else begin
         valid_o <= 1'b0;
         data_o <= ~data_o;
      end
      wait_q <= (req_i && !valid_o) ? wait_q + 2'h1 : 2'h0;
   end
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the data buffer block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk_i = 1'b0, rst_n_i = 1'b0, ce = 1'b0, stp = 1'b0;
   logic        hw = 1'b0, we = 1'b0, wide = 1'b1, low = 1'b0, fld = 1'b0;
   logic [3:0]  bank = 4'h0, wd = 4'h0, op = 4'h0, rdat, dir;
   logic [6:0]  maddr = 7'h0F, pa = 7'h00;
   logic        pval, preq, hold, busy, seen;
   logic [1:0]  lat = 2'h0;
   logic [7:0]  adc;
   logic [8:0]  da, db, dc;
   logic [15:0] paddr, pdat, fcnt = 16'h0000, bo, v, w, m;
   logic [16:0] syn;
   logic [23:0] tmc = 24'h000000;
   int          n_fail = 0, n_checks = 0, i, j, k;
   logic [6:0]  rw [0:11] = '{7'h02, 7'h03, 7'h04, 7'h1A, 7'h1C, 7'h1E,
                              7'h40, 7'h41, 7'h42, 7'h44, 7'h45, 7'h46};
   always #20 clk_i = ~clk_i;
   dbp_top i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_rst_i(ce),
      .clk_stop_i(stp), .adc_hw_mode_i(hw), .mem_we_i(we), .mem_bank_i(bank),
      .mem_addr_i(maddr), .mem_wdata_i(wd), .mem_rdata_o(rdat), .op_i(op),
      .op_paddr_i(pa), .tbl_wide_i(wide), .pmem_addr_o(paddr),
      .pmem_req_o(preq), .pmem_data_i(pdat), .pmem_valid_i(pval),
      .stack_hold_o(hold), .busy_o(busy), .synth_count_low_bit_i(low),
      .synth_count_o(syn), .tm_count_i(tmc), .freq_count_i(fcnt),
      .freq_load_i(fld), .transfer_buffer_o(bo), .port_a0_dir_o(dir),
      .pwm_duty_a_o(da), .pwm_duty_b_o(db), .pwm_duty_c_o(dc),
      .adc_reference_level_o(adc));
   dbp_pmem_model i_pmem (.clk_i(clk_i), .lat_i(lat), .addr_i(paddr),
      .req_i(preq), .data_o(pdat), .valid_o(pval));
   ////////////////////////////////////////////////////////////////////////
   // Bus cycles, comparison and the closing report.
   task automatic step(int n = 1);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic check(logic [15:0] got, logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Leaves the write strobe up so back-to-back writes keep it steady.
   task automatic mem_wr(logic [3:0] b, logic [6:0] a, logic [3:0] d);
      we = 1'b1;
      bank = b;
      maddr = a;
      wd = d;
      step();
   endtask
   task automatic set_buf(logic [15:0] val);
      for (k = 0; k < 4; k++) mem_wr(4'h0, 7'h0C + 7'(k), val[15-4*k -: 4]);
      we = 1'b0;
      step();
   endtask
   task automatic do_op(logic [3:0] o, logic [6:0] a);
      op = o;
      pa = a;
      step();
      op = 4'h0;
      step();
   endtask
   task automatic pulse(input int sel);
      if (sel == 0) ce = 1'b1;
      else stp = 1'b1;
      step();
      ce = 1'b0;
      stp = 1'b0;
      step();
   endtask
   // Reads a register into a cleared buffer and compares the result.
   task automatic get_chk(logic [6:0] a, logic [15:0] exp);
      set_buf(16'h0000);
      do_op(4'h2, a);
      check(bo, exp);
   endtask
   function automatic logic [15:0] mask_of(int idx);
      return (idx > 8) ? 16'h01FF : 16'hFFFF;
   endfunction
   ////////////////////////////////////////////////////////////////////////
   // Main sequence: reset values, register traffic, table reads, resets.
   initial begin
      void'($urandom(9));
      low = 1'($urandom);
      step(12);
      rst_n_i = 1'b1;
      step(3);
      check({7'h00, da}, 16'h01FF);
      check({dir, adc, 4'h0}, 16'h0000);
      get_chk(7'h1A, 16'h00FF);
      get_chk(7'h40, 16'h0000);
      get_chk(7'h43, 16'h0000);
      for (j = 0; j < 24; j++) begin
         i = j % 12;
         v = 16'($urandom);
         w = 16'($urandom);
         set_buf(v);
         check(bo, v);
         check({12'h000, rdat}, {12'h000, v[3:0]});
         do_op(4'h3, rw[i]);
         if (i == 8) check(syn[15:0], {v[14:0], low});
         if (i == 10) check({7'h00, db}, {7'h00, v[8:0]});
         set_buf(w);
         do_op(4'h2, rw[i]);
         m = mask_of(i);
         if (i < 6) check(bo, {w[15:8], v[7:0]});
         else check(bo & m, v & m);
      end
      tmc = 24'($urandom);
      get_chk(7'h1B, {8'h00, tmc[7:0]});
      get_chk(7'h1D, {8'h00, tmc[15:8]});
      get_chk(7'h1F, {8'h00, tmc[23:16]});
      fcnt = 16'($urandom);
      fld = 1'b1;
      step();
      fld = 1'b0;
      get_chk(7'h43, fcnt);
      set_buf(~fcnt);
      do_op(4'h3, 7'h43);
      do_op(4'h3, 7'h1B);
      do_op(4'h3, 7'h05);
      get_chk(7'h43, fcnt);
      check({7'h00, dc}, {7'h00, v[8:0]});
      // Table reads at every latency, both widths.
      for (j = 0; j < 4; j++) begin
         lat = 2'(j);
         wide = j[0];
         v = 16'($urandom);
         w = 16'($urandom);
         set_buf(v);
         do_op(4'h3, 7'h40);
         set_buf(w);
         op = 4'h1;
         step();
         op = 4'h0;
         seen = 1'b0;
         for (k = 0; k < 30 && busy !== 1'b0; k++) begin
            seen = seen | (hold === 1'b1);
            step();
         end
         if (k == 30) begin
            n_fail++;
            conclude();
         end
         check(paddr, v);
         check({15'h0000, seen}, 16'h0001);
         if (wide) check(bo, v ^ 16'h5A3C);
         else check(bo, {w[15:8], v[7:0] ^ 8'h3C});
      end
      // Reset classes: what survives a CE reset and a clock stop.
      v = 16'($urandom);
      mem_wr(4'hF, 7'h6F, v[3:0]);
      we = 1'b0;
      step();
      check({12'h000, dir}, {12'h000, v[3:0]});
      set_buf(16'h0012);
      do_op(4'h3, 7'h1A);
      do_op(4'h3, 7'h44);
      do_op(4'h3, 7'h40);
      do_op(4'h3, 7'h02);
      pulse(0);
      check({dir, 3'h0, da}, {v[3:0], 12'h012});
      check({8'h00, adc}, 16'h0012);
      get_chk(7'h1A, 16'h0012);
      get_chk(7'h40, 16'h0000);
      hw = 1'b1;
      pulse(0);
      check({8'h00, adc}, 16'h0000);
      // The pointer is loaded after the CE reset, which would clear it.
      set_buf(16'hBEEF);
      do_op(4'h3, 7'h40);
      pulse(1);
      check({dir, 3'h0, da}, {v[3:0], 12'h1FF});
      get_chk(7'h1A, 16'h00FF);
      get_chk(7'h40, 16'hBEEF);
      conclude();
   end
endmodule
`default_nettype wire
